// ---- sim/field_side.sv ----
// field side model: terminal contacts and a digital pulse meter
// assumes the bench sets contact levels just after a rising edge
module field_side (
	// clock
	input wire logic i_clock,
	// contact levels wanted by the bench {rev,fwd,trg,in3,in2,in1}
	input wire logic [5:0] i_close,
	// pulse train from the drive
	input wire logic i_pulse,
	// contacts seen at the terminals
	output logic [5:0] o_pins,
	// last measured high and low times in clocks
	output logic [15:0] o_high_len,
	output logic [15:0] o_low_len
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] run_r = 16'h0000; // clocks since the last pulse edge
	logic last_r = 1'b0; // pulse level one clock ago
	initial begin
		o_pins = 6'h00;
		o_high_len = 16'h0000;
		o_low_len = 16'h0000;
	end
	// ---------------------------------------------
	// contacts follow the bench, meter times each level
	// ---------------------------------------------
	always @(posedge i_clock) begin
		o_pins <= i_close;
		last_r <= i_pulse;
		run_r <= (i_pulse != last_r) ? 16'h0001 : run_r + 16'h0001;
		// a level ends: latch its length
		if (i_pulse && !last_r) begin
			o_low_len <= run_r;
		end
		if (!i_pulse && last_r) begin
			o_high_len <= run_r;
		end
	end
endmodule

// ---- sim/testbench.sv ----
// self-checking bench for the terminal logic
// assumes terminal_pkg, the design files and field_side come first
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import terminal_pkg::*;
	// ---------------------------------------------
	// signals
	// ---------------------------------------------
	logic i_clock = 1'b0;
	logic i_nrst = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [15:0] i_wdata = 16'h0000;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [15:0] o_rdata;
	logic [5:0] close = 6'h00; // wanted contacts
	logic [5:0] pins;
	logic pulse;
	logic [15:0] high_len;
	logic [15:0] low_len;
	logic mo1;
	logic mo2;
	logic [11:0] out_freq = 12'h064;
	logic [11:0] master = 12'h123;
	logic [11:0] min_freq = 12'h0C8;
	logic active = 1'b0;
	logic torque = 1'b0;
	logic lowv = 1'b0;
	logic fault = 1'b0;
	logic remote = 1'b0;
	logic [11:0] cmd;
	logic [2:0] idx;
	logic jog, hold, ramp2, block, up, down;
	int fails = 0;
	int compares = 0;
	int cycles = 0;
	// ---------------------------------------------
	// instances
	// ---------------------------------------------
	drive_terminals u_dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_multi_input_first(pins[0]),
		.i_multi_input_second(pins[1]), .i_multi_input_third(pins[2]), .i_counter_trigger_input(pins[3]),
		.i_forward_run_command(pins[4]), .i_reverse_run_command(pins[5]), .o_multi_output_first(mo1),
		.o_multi_output_second(mo2), .o_pulse_frequency_output(pulse), .i_output_freq(out_freq),
		.i_master_freq(master), .i_min_freq(min_freq), .i_output_active(active), .i_over_torque(torque),
		.i_low_voltage(lowv), .i_major_fault(fault), .i_remote_mode(remote), .o_freq_command(cmd),
		.o_step_index(idx), .o_jog_select(jog), .o_ramp_hold(hold), .o_ramp_set2(ramp2),
		.o_output_block(block), .o_trim_up(up), .o_trim_down(down));
	field_side u_field (.i_clock(i_clock), .i_close(close), .i_pulse(pulse), .o_pins(pins),
		.o_high_len(high_len), .o_low_len(low_len));
	// ---------------------------------------------
	// clock and hang guard
	// ---------------------------------------------
	initial begin
		forever #50 i_clock = ~i_clock;
	end
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 40000) begin
			fails++;
			report_and_stop();
		end
	end
	// ---------------------------------------------
	// tasks
	// ---------------------------------------------
	task automatic report_and_stop();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clock);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask
	// read, data checked in the cycle after the strobe
	task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
		@(posedge i_clock);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1 check(o_rdata, exp);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask
	// expected {jog,hold,ramp2,block,up,down} for code c, pin closed p
	function automatic logic [15:0] fn_exp(input int c, input int p);
		if (c == 7)
			return p ? 16'h0000 : 16'h0004;
		return p ? 16'(6'h20 >> (c - 3 - ((c > 7) ? 1 : 0))) : 16'h0000;
	endfunction
	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial begin
		repeat (16) @(posedge i_clock);
		i_nrst <= 1'b1;
		rdc(OFS_IN_SEL0, 16'h0000);
		rdc(8'h04, 16'h0001);
		rdc(8'h08, 16'h0002);
		rdc(OFS_OUT_SEL0, 16'h0000);
		rdc(8'h10, 16'h0001);
		rdc(OFS_MULT, 16'h0001);
		rdc(OFS_DESIRED, 16'h0000);
		rdc(8'h44, 16'h0000);
		// out-of-range writes keep the old value
		wr(OFS_IN_SEL0, 16'h000A);
		rdc(OFS_IN_SEL0, 16'h0000);
		wr(OFS_OUT_SEL0, 16'h000F);
		rdc(OFS_OUT_SEL0, 16'h0000);
		wr(OFS_MULT, 16'h0015);
		rdc(OFS_MULT, 16'h0001);
		// step settings and every step index
		for (int k = 1; k < 8; k++)
			wr(8'(8'h24 + 4 * (k - 1)), 16'(k * 100));
		for (int k = 0; k < 8; k++) begin
			@(posedge i_clock);
			close <= 6'(k);
			settle(8);
			check(16'(idx), 16'(k));
			check(16'(cmd), (k == 0) ? 16'h0123 : 16'(k * 100));
		end
		// input functions 3..9 on the third input, closed and open
		for (int c = 3; c < 10; c++) begin
			wr(8'h08, 16'(c));
			for (int p = 0; p < 2; p++) begin
				@(posedge i_clock);
				close <= p ? 6'h04 : 6'h00;
				settle(8);
				check({10'h000, jog, hold, ramp2, block, up, down}, fn_exp(c, p));
				if (c == 3 && p == 1)
					check(16'(cmd), 16'(JOG_RST));
			end
		end
		// up and down closed together hold the frequency
		wr(8'h04, 16'h0008);
		@(posedge i_clock);
		close <= 6'h06;
		settle(8);
		check({13'h0000, hold, up, down}, 16'h0004);
		rdc(OFS_STATUS, 16'h0C28);
		// output conditions, each false then true, on both contacts
		for (int c = 0; c < 10; c++) begin
			wr(OFS_OUT_SEL0, 16'(c));
			wr(8'h10, 16'(c));
			for (int p = 0; p < 2; p++) begin
				if (c == 3)
					wr(OFS_COUNT, p ? 16'h0003 : 16'h0005);
				@(posedge i_clock);
				active <= (c == 6) ? (p == 0) : ((c == 1 || c == 2) && p == 1);
				out_freq <= (c == 2) ? 12'h000 : (c == 1) ? 12'h123 : (c == 4 && p == 1) ? 12'h190 : 12'h064;
				close <= (c == 0 && p == 1) ? 6'h10 : 6'h00;
				torque <= (c == 5 && p == 1);
				lowv <= (c == 7 && p == 1);
				remote <= (c == 8 && p == 1);
				fault <= (c == 9 && p == 1);
				settle(8);
				// two trigger closings bring a preset of 3 down to 1
				for (int t = 0; t < ((c == 3) ? 4 * p : 0); t++) begin
					@(posedge i_clock);
					close <= t[0] ? 6'h00 : 6'h08;
					settle(8);
				end
				check({14'h0000, mo2, mo1}, p ? 16'h0003 : 16'h0000);
				if (c == 3 && p == 1)
					rdc(OFS_COUNT, 16'h0001);
			end
		end
		// pulse train: 50.0 Hz times 20 is 1000 pulses per second
		@(posedge i_clock);
		out_freq <= 12'h1F4;
		wr(OFS_MULT, 16'h0014);
		rdc(OFS_MULT, 16'h0014);
		settle(16000);
		check(16'(high_len > 16'd4998 && high_len < 16'd5002), 16'h0001);
		check(16'(low_len > 16'd4998 && low_len < 16'd5002), 16'h0001);
		report_and_stop();
	end
endmodule

// ---- verilog/drive_terminals.sv ----
// multi-function terminal logic of the motor drive
// assumes pins are asynchronous, drive core signals share i_clock
module drive_terminals (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_nrst,
	// register port
	input wire logic [terminal_pkg::ADDR_W-1:0] i_addr,
	input wire logic [terminal_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [terminal_pkg::DATA_W-1:0] o_rdata,
	// terminal pins, high means closed
	input wire logic i_multi_input_first,
	input wire logic i_multi_input_second,
	input wire logic i_multi_input_third,
	input wire logic i_counter_trigger_input,
	input wire logic i_forward_run_command,
	input wire logic i_reverse_run_command,
	output logic o_multi_output_first,
	output logic o_multi_output_second,
	output logic o_pulse_frequency_output,
	// drive core status
	input wire logic [terminal_pkg::FREQ_W-1:0] i_output_freq,
	input wire logic [terminal_pkg::FREQ_W-1:0] i_master_freq,
	input wire logic [terminal_pkg::FREQ_W-1:0] i_min_freq,
	input wire logic i_output_active,
	input wire logic i_over_torque,
	input wire logic i_low_voltage,
	input wire logic i_major_fault,
	input wire logic i_remote_mode,
	// drive core commands
	output logic [terminal_pkg::FREQ_W-1:0] o_freq_command,
	output logic [2:0] o_step_index,
	output logic o_jog_select,
	output logic o_ramp_hold,
	output logic o_ramp_set2,
	output logic o_output_block,
	output logic o_trim_up,
	output logic o_trim_down
);
	import terminal_pkg::*;

	// ---------------------------------------------
	// functions
	// ---------------------------------------------
	// one-hot of a function code
	function automatic logic [9:0] code_hot(input logic [3:0] c);
		code_hot = 10'h001 << c;
	endfunction

	// selector write value in range
	function automatic logic code_ok(input logic [DATA_W-1:0] v);
		code_ok = v <= DATA_W'(CODE_MAX);
	endfunction

	// frequency write value in range
	function automatic logic freq_ok(input logic [DATA_W-1:0] v);
		freq_ok = v <= DATA_W'(FREQ_MAX);
	endfunction

	// ---------------------------------------------
	// pin synchronisers
	// ---------------------------------------------
	wire logic [PIN_N-1:0] pin_raw; // raw pin levels
	logic [PIN_N-1:0] s1_r; // first stage
	logic [PIN_N-1:0] s2_r; // second stage
	logic [PIN_N-1:0] s3_r; // third stage
	logic [PIN_N-1:0] pin_r; // accepted level

	assign pin_raw = {i_reverse_run_command, i_forward_run_command,
		i_counter_trigger_input, i_multi_input_third,
		i_multi_input_second, i_multi_input_first};

	// accept a change once stages two and three agree
	genvar gp;
	generate
		for (gp = 0; gp < PIN_N; gp++) begin : g_pin
			always_ff @(posedge i_clock or negedge i_nrst) begin
				if (!i_nrst) begin
					s1_r[gp] <= 1'b0;
					s2_r[gp] <= 1'b0;
					s3_r[gp] <= 1'b0;
					pin_r[gp] <= 1'b0;
				end else begin
					s1_r[gp] <= pin_raw[gp];
					s2_r[gp] <= s1_r[gp];
					s3_r[gp] <= s2_r[gp];
					if (s2_r[gp] == s3_r[gp]) begin
						pin_r[gp] <= s3_r[gp];
					end
				end
			end
		end
	endgenerate

	// ---------------------------------------------
	// register write decode
	// ---------------------------------------------
	logic [3:0] in_sel_r [0:2]; // input function codes
	logic [3:0] out_sel_r [0:1]; // output condition codes
	logic [4:0] mult_r; // pulse multiplier
	logic [11:0] desired_r; // desired frequency
	logic [11:0] jog_r; // jog frequency
	logic [11:0] step_r [1:7]; // step-speed settings
	wire logic wr_mult; // multiplier write
	wire logic wr_desired; // desired write
	wire logic wr_jog; // jog write
	wire logic wr_count; // counter preset write
	wire logic mult_ok; // multiplier value in range

	assign wr_mult = i_wr && i_addr == OFS_MULT;
	assign wr_desired = i_wr && i_addr == OFS_DESIRED;
	assign wr_jog = i_wr && i_addr == OFS_JOG;
	assign wr_count = i_wr && i_addr == OFS_COUNT;
	assign mult_ok = i_wdata >= DATA_W'(MULT_MIN) &&
		i_wdata <= DATA_W'(MULT_MAX);

	// input selectors, out-of-range codes dropped
	localparam logic [3:0] IN_RST [0:2] = '{IN_SEL0_RST,
		IN_SEL1_RST, IN_SEL2_RST};
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_in_sel
			always_ff @(posedge i_clock or negedge i_nrst) begin
				if (!i_nrst) begin
					in_sel_r[gi] <= IN_RST[gi];
				end else if (i_wr && i_addr == OFS_IN_SEL0 +
					ADDR_W'(4 * gi) && code_ok(i_wdata)) begin
					in_sel_r[gi] <= i_wdata[3:0];
				end
			end
		end
	endgenerate

	// output selectors, out-of-range codes dropped
	localparam logic [3:0] OUT_RST [0:1] = '{OUT_SEL0_RST,
		OUT_SEL1_RST};
	genvar go;
	generate
		for (go = 0; go < 2; go++) begin : g_out_sel
			always_ff @(posedge i_clock or negedge i_nrst) begin
				if (!i_nrst) begin
					out_sel_r[go] <= OUT_RST[go];
				end else if (i_wr && i_addr == OFS_OUT_SEL0 +
					ADDR_W'(4 * go) && code_ok(i_wdata)) begin
					out_sel_r[go] <= i_wdata[3:0];
				end
			end
		end
	endgenerate

	// step-speed settings one to seven
	genvar gs;
	generate
		for (gs = 1; gs < 8; gs++) begin : g_step
			always_ff @(posedge i_clock or negedge i_nrst) begin
				if (!i_nrst) begin
					step_r[gs] <= STEP_RST;
				end else if (i_wr && i_addr == OFS_STEP1 +
					ADDR_W'(4 * (gs - 1)) && freq_ok(i_wdata)) begin
					step_r[gs] <= i_wdata[11:0];
				end
			end
		end
	endgenerate

	// scalar settings
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			mult_r <= MULT_RST;
			desired_r <= DESIRED_RST;
			jog_r <= JOG_RST;
		end else begin
			if (wr_mult && mult_ok) begin
				mult_r <= i_wdata[4:0];
			end
			if (wr_desired && freq_ok(i_wdata)) begin
				desired_r <= i_wdata[11:0];
			end
			if (wr_jog && freq_ok(i_wdata)) begin
				jog_r <= i_wdata[11:0];
			end
		end
	end

	// ---------------------------------------------
	// input function decode
	// ---------------------------------------------
	wire logic [9:0] in_hot [0:2]; // code per input
	wire logic [9:0] fn_closed; // function active
	wire logic [9:0] fn_assigned; // function mapped
	wire logic up; // up trim closed
	wire logic dn; // down trim closed

	generate
		for (gi = 0; gi < 3; gi++) begin : g_hot
			assign in_hot[gi] = code_hot(in_sel_r[gi]);
		end
	endgenerate

	assign fn_closed = (in_hot[0] & {10{pin_r[0]}}) |
		(in_hot[1] & {10{pin_r[1]}}) |
		(in_hot[2] & {10{pin_r[2]}});
	assign fn_assigned = in_hot[0] | in_hot[1] | in_hot[2];
	assign up = fn_closed[FN_UP];
	assign dn = fn_closed[FN_DOWN];

	// ---------------------------------------------
	// drive commands
	// ---------------------------------------------
	wire logic [2:0] idx_nxt; // step index
	wire logic [11:0] freq_nxt; // frequency command
	wire logic hold_nxt; // ramp hold
	wire logic block_nxt; // output block
	logic [11:0] freq_r; // frequency command
	logic [2:0] idx_r; // step index
	logic jog_sel_r; // jog selected
	logic hold_r; // ramp hold
	logic ramp2_r; // second ramp pair
	logic block_r; // output blocked
	logic up_r; // raise frequency
	logic dn_r; // lower frequency

	assign idx_nxt = fn_closed[2:0];
	// jog wins; index zero keeps master reference
	assign freq_nxt = fn_closed[FN_JOG] ? jog_r :
		(idx_nxt == 3'h0) ? i_master_freq : step_r[idx_nxt];
	// both trims closed also hold
	assign hold_nxt = fn_closed[FN_HOLD] | (up & dn);
	// no-contact closed or nc-contact open
	assign block_nxt = fn_closed[FN_BLOCK_NO] |
		(fn_assigned[FN_BLOCK_NC] & ~fn_closed[FN_BLOCK_NC]);

	// command registers
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			freq_r <= '0;
			idx_r <= '0;
			jog_sel_r <= 1'b0;
			hold_r <= 1'b0;
			ramp2_r <= 1'b0;
			block_r <= 1'b0;
			up_r <= 1'b0;
			dn_r <= 1'b0;
		end else begin
			freq_r <= freq_nxt;
			idx_r <= idx_nxt;
			jog_sel_r <= fn_closed[FN_JOG];
			hold_r <= hold_nxt;
			ramp2_r <= fn_closed[FN_RAMP2];
			block_r <= block_nxt;
			up_r <= up & ~dn;
			dn_r <= dn & ~up;
		end
	end

	assign o_freq_command = freq_r;
	assign o_step_index = idx_r;
	assign o_jog_select = jog_sel_r;
	assign o_ramp_hold = hold_r;
	assign o_ramp_set2 = ramp2_r;
	assign o_output_block = block_r;
	assign o_trim_up = up_r;
	assign o_trim_down = dn_r;

	// ---------------------------------------------
	// trigger down-counter
	// ---------------------------------------------
	logic [15:0] count_r; // remaining count
	logic trg_prev_r; // trigger last level
	wire logic trg_rise; // trigger closing edge
	wire logic count_done; // count at one

	assign trg_rise = pin_r[PIN_TRG] & ~trg_prev_r;
	assign count_done = count_r == 16'h0001;

	// reload on preset write, count down on trigger
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			count_r <= COUNT_RST;
			trg_prev_r <= 1'b0;
		end else begin
			trg_prev_r <= pin_r[PIN_TRG];
			if (wr_count) begin
				count_r <= i_wdata;
			end else if (trg_rise && count_r > 16'h0001) begin
				count_r <= count_r - 16'h0001;
			end
		end
	end

	// ---------------------------------------------
	// output conditions
	// ---------------------------------------------
	wire logic [9:0] cond; // condition per code
	logic [1:0] mo_r; // output contacts

	assign cond[0] = i_output_active | pin_r[PIN_FWD] |
		pin_r[PIN_REV];
	assign cond[1] = i_output_active &&
		i_output_freq == freq_r;
	assign cond[2] = i_output_active &&
		i_output_freq == desired_r;
	assign cond[3] = count_done;
	assign cond[4] = i_output_freq > i_min_freq;
	assign cond[5] = i_over_torque;
	assign cond[6] = ~i_output_active;
	assign cond[7] = i_low_voltage;
	assign cond[8] = i_remote_mode;
	assign cond[9] = i_major_fault;

	// contact closes while its condition holds
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			mo_r <= 2'h0;
		end else begin
			mo_r[0] <= cond[out_sel_r[0]];
			mo_r[1] <= cond[out_sel_r[1]];
		end
	end

	assign o_multi_output_first = mo_r[0];
	assign o_multi_output_second = mo_r[1];

	// ---------------------------------------------
	// frequency pulse output
	// ---------------------------------------------
	pulse_synth u_pulse (
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.i_freq(i_output_freq),
		.i_mult(mult_r),
		.o_pulse(o_pulse_frequency_output)
	);

	// ---------------------------------------------
	// read port
	// ---------------------------------------------
	logic [15:0] rdata_r; // read data
	logic [15:0] rdata_nxt; // selected word
	wire logic [15:0] status; // live state

	// one spare bit keeps the word at sixteen
	assign status = {1'h0, pin_r, mo_r, block_r, hold_r,
		jog_sel_r, count_done, idx_r};

	// unmapped addresses read zero
	always_comb begin
		case (i_addr)
			8'h00: rdata_nxt = {12'h000, in_sel_r[0]};
			8'h04: rdata_nxt = {12'h000, in_sel_r[1]};
			8'h08: rdata_nxt = {12'h000, in_sel_r[2]};
			8'h0C: rdata_nxt = {12'h000, out_sel_r[0]};
			8'h10: rdata_nxt = {12'h000, out_sel_r[1]};
			OFS_MULT: rdata_nxt = {11'h000, mult_r};
			OFS_DESIRED: rdata_nxt = {4'h0, desired_r};
			OFS_COUNT: rdata_nxt = count_r;
			OFS_JOG: rdata_nxt = {4'h0, jog_r};
			8'h24: rdata_nxt = {4'h0, step_r[1]};
			8'h28: rdata_nxt = {4'h0, step_r[2]};
			8'h2C: rdata_nxt = {4'h0, step_r[3]};
			8'h30: rdata_nxt = {4'h0, step_r[4]};
			8'h34: rdata_nxt = {4'h0, step_r[5]};
			8'h38: rdata_nxt = {4'h0, step_r[6]};
			8'h3C: rdata_nxt = {4'h0, step_r[7]};
			OFS_STATUS: rdata_nxt = status;
			default: rdata_nxt = 16'h0000;
		endcase
	end

	// data stand one cycle, zero otherwise
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			rdata_r <= 16'h0000;
		end else begin
			rdata_r <= i_rd ? rdata_nxt : 16'h0000;
		end
	end

	assign o_rdata = rdata_r;

	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	a_sel_reject: assert property (
		@(posedge i_clock) disable iff (!i_nrst)
		i_wr && i_addr == OFS_IN_SEL0 && i_wdata > 16'h0009
		|=> $stable(in_sel_r[0]))
		else $error("bad selector code stored");

	a_step_index: assert property (
		@(posedge i_clock) disable iff (!i_nrst)
		!fn_closed[FN_JOG] && fn_closed[2:0] != 3'h0
		|=> o_step_index == $past(fn_closed[2:0]) &&
		o_freq_command == step_r[o_step_index])
		else $error("step frequency not selected");

	a_jog_select: assert property (
		@(posedge i_clock) disable iff (!i_nrst)
		fn_closed[FN_JOG] |=> o_jog_select &&
		o_freq_command == $past(jog_r))
		else $error("jog frequency not selected");

	a_ramp_hold: assert property (
		@(posedge i_clock) disable iff (!i_nrst)
		fn_closed[FN_HOLD] |=> o_ramp_hold)
		else $error("hold input ignored");

	a_ramp_pair: assert property (
		@(posedge i_clock) disable iff (!i_nrst)
		##1 o_ramp_set2 == $past(fn_closed[FN_RAMP2]))
		else $error("ramp pair wrong");

	a_block_open: assert property (
		@(posedge i_clock) disable iff (!i_nrst)
		fn_assigned[FN_BLOCK_NC] && !fn_closed[FN_BLOCK_NC]
		|=> o_output_block)
		else $error("open nc input did not block");

	a_trim_both: assert property (
		@(posedge i_clock) disable iff (!i_nrst)
		up && dn |=> o_ramp_hold && !o_trim_up && !o_trim_down)
		else $error("both trims not held");

	a_run_contact: assert property (
		@(posedge i_clock) disable iff (!i_nrst)
		out_sel_r[0] == OUT_RUN && pin_r[PIN_FWD]
		&& $stable(out_sel_r[0]) |=> o_multi_output_first)
		else $error("run contact open");

	a_count_done: assert property (
		@(posedge i_clock) disable iff (!i_nrst)
		count_r == 16'h0001 && out_sel_r[1] == OUT_COUNT
		|=> o_multi_output_second)
		else $error("count contact open");
endmodule

// ---- verilog/pulse_synth.sv ----
// digital frequency pulse synthesiser
// assumes frequency in 0.1 Hz steps and a 10 MHz clock
module pulse_synth #(
	parameter int ACC_W = 27
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_nrst,
	// rate
	input wire logic [terminal_pkg::FREQ_W-1:0] i_freq,
	input wire logic [terminal_pkg::MULT_W-1:0] i_mult,
	// pulse
	output logic o_pulse
);
	import terminal_pkg::*;
	// ---------------------------------------------
	// phase accumulator
	// ---------------------------------------------
	localparam logic [ACC_W-1:0] TH = ACC_W'(PULSE_TOGGLE_TH);
	logic [ACC_W-1:0] acc_r; // phase
	logic [ACC_W-1:0] acc_nxt; // next phase
	logic pulse_r; // pulse level
	wire logic [FREQ_W+MULT_W-1:0] step; // tenths of hz times mult
	wire logic [ACC_W-1:0] sum; // advanced phase
	wire logic wrap; // half period done
	assign step = i_freq * i_mult;
	assign sum = acc_r + ACC_W'(step);
	assign wrap = sum >= TH;
	assign acc_nxt = wrap ? sum - TH : sum;
	// toggle at each half period, equal high and low
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			acc_r <= '0;
			pulse_r <= 1'b0;
		end else begin
			acc_r <= acc_nxt;
			pulse_r <= pulse_r ^ wrap;
		end
	end
	assign o_pulse = pulse_r;
	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	a_pulse_hold: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(step == '0) [*2] |-> $stable(o_pulse))
		else $error("pulse moved with zero rate");
endmodule

// ---- verilog/terminal_pkg.sv ----
// terminal logic constants: register map, field codes, reset values
// assumes one 10 MHz clock and frequencies in 0.1 Hz steps
package terminal_pkg;
	// ---------------------------------------------
	// widths
	// ---------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int FREQ_W = 12;
	localparam int CODE_W = 4;
	localparam int MULT_W = 5;
	localparam int CNT_W = 16;
	localparam int PIN_N = 6;
	// ---------------------------------------------
	// register offsets
	// ---------------------------------------------
	localparam logic [7:0] OFS_IN_SEL0 = 8'h00;
	localparam logic [7:0] OFS_OUT_SEL0 = 8'h0C;
	localparam logic [7:0] OFS_MULT = 8'h14;
	localparam logic [7:0] OFS_DESIRED = 8'h18;
	localparam logic [7:0] OFS_COUNT = 8'h1C;
	localparam logic [7:0] OFS_JOG = 8'h20;
	localparam logic [7:0] OFS_STEP1 = 8'h24;
	localparam logic [7:0] OFS_STATUS = 8'h40;
	// ---------------------------------------------
	// reset values and limits
	// ---------------------------------------------
	localparam logic [3:0] IN_SEL0_RST = 4'h0;
	localparam logic [3:0] IN_SEL1_RST = 4'h1;
	localparam logic [3:0] IN_SEL2_RST = 4'h2;
	localparam logic [3:0] OUT_SEL0_RST = 4'h0;
	localparam logic [3:0] OUT_SEL1_RST = 4'h1;
	localparam logic [3:0] CODE_MAX = 4'h9;
	localparam logic [4:0] MULT_RST = 5'h01;
	localparam logic [4:0] MULT_MIN = 5'h01;
	localparam logic [4:0] MULT_MAX = 5'h14;
	localparam logic [11:0] FREQ_MAX = 12'hFA0;
	localparam logic [11:0] DESIRED_RST = 12'h000;
	localparam logic [11:0] JOG_RST = 12'h03C;
	localparam logic [11:0] STEP_RST = 12'h000;
	localparam logic [15:0] COUNT_RST = 16'h0001;
	// ---------------------------------------------
	// input functions, output conditions, pins
	// ---------------------------------------------
	localparam int FN_JOG = 3;
	localparam int FN_HOLD = 4;
	localparam int FN_RAMP2 = 5;
	localparam int FN_BLOCK_NO = 6;
	localparam int FN_BLOCK_NC = 7;
	localparam int FN_UP = 8;
	localparam int FN_DOWN = 9;
	localparam logic [3:0] OUT_RUN = 4'h0;
	localparam logic [3:0] OUT_COUNT = 4'h3;
	localparam int PIN_TRG = 3;
	localparam int PIN_FWD = 4;
	localparam int PIN_REV = 5;
	// ---------------------------------------------
	// timing
	// ---------------------------------------------
	localparam int CLOCK_HZ = 10_000_000;
	localparam int STEPS_PER_HZ = 10;
	// toggle threshold: two edges per pulse period
	localparam int PULSE_TOGGLE_TH = CLOCK_HZ * STEPS_PER_HZ / 2;
endpackage
